// ### hdl/ccl_sync.sv
// Purpose: Two-flop synchroniser with registered previous sample
// Assumes: Clock enable freezes all state
// Notes: First flop is read only by the second
`timescale 1ns/100ps
module ccl_sync (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic d,
   output logic q,
   output logic q_prev
);
   logic meta;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= 1'b0;
         q <= 1'b0;
         q_prev <= 1'b0;
      end else if (clk_en) begin
         meta <= d;
         q <= meta;
         q_prev <= q;
      end
   end
endmodule : ccl_sync

// ### hdl/ccl_top.sv
// Purpose: Digital control around an analog voltage comparator
// Assumes: Analog compare done outside; raw_compare is its decision
// Notes: Single output-control register; others arrive as plain inputs
`timescale 1ns/100ps
module ccl_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire ccl_pkg::ccl_reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   input wire ccl_pkg::ccl_mux_cfg_s mux_cfg,
   output logic [ccl_pkg::CHAN_SEL_W-1:0] neg_channel_sel,
   output logic neg_use_channel,
   input wire logic raw_compare,
   input wire logic capture_route_enable,
   input wire logic irq_enable,
   input wire ccl_pkg::ccl_edge_mode_e irq_edge_mode,
   input wire logic irq_flag_clear,
   output logic compare_result,
   output logic capture_trigger,
   output logic irq_flag,
   output logic irq_request,
   output logic result_pin,
   output logic result_pin_oe
);
   // ------------------------------------------------------------
   // Negative input selection
   // ------------------------------------------------------------
   // Borrow only when converter is off; power reduce is software's duty
   wire logic borrow_mux = mux_cfg.mux_borrow_enable & ~mux_cfg.converter_enable;
   logic neg_use_q;
   logic [ccl_pkg::CHAN_SEL_W-1:0] neg_sel_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         neg_use_q <= 1'b0;
         neg_sel_q <= '0;
      end else if (clk_en) begin
         neg_use_q <= borrow_mux;
         neg_sel_q <= mux_cfg.channel_select_low;
      end
   end
   assign neg_use_channel = neg_use_q;
   assign neg_channel_sel = neg_sel_q;

   // ------------------------------------------------------------
   // Result sampling
   // ------------------------------------------------------------
   logic res_q;
   logic res_prev;

   ccl_sync u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .d(raw_compare),
      .q(res_q),
      .q_prev(res_prev)
   );
   assign compare_result = res_q;

   // ------------------------------------------------------------
   // Edge detect and interrupt flag
   // ------------------------------------------------------------
   wire logic rise = res_q & ~res_prev;
   wire logic fall = ~res_q & res_prev;
   logic edge_hit;

   always_comb begin
      unique case (irq_edge_mode)
         ccl_pkg::CCL_EDGE_TOGGLE: edge_hit = rise | fall;
         ccl_pkg::CCL_EDGE_FALL: edge_hit = fall;
         ccl_pkg::CCL_EDGE_RISE: edge_hit = rise;
         default: edge_hit = 1'b0;
      endcase
   end

   logic flag_q;
   // Set wins over a clear in the same cycle
   wire logic next_flag = edge_hit | (flag_q & ~irq_flag_clear);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= 1'b0;
      end else if (clk_en) begin
         flag_q <= next_flag;
      end
   end
   assign irq_flag = flag_q;
   assign irq_request = flag_q & irq_enable;

   // ------------------------------------------------------------
   // Timer capture path
   // ------------------------------------------------------------
   logic cap_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cap_q <= 1'b0;
      end else if (clk_en) begin
         cap_q <= capture_route_enable & res_q;
      end
   end
   assign capture_trigger = cap_q;

   // ------------------------------------------------------------
   // Output-control register
   // ------------------------------------------------------------
   wire logic [7:0] io_ofs = ccl_pkg::OUT_CTRL_DATA_OFS - ccl_pkg::IO_SPACE_BASE;
   wire logic io_ok = reg_req.addr <= ccl_pkg::IO_SPACE_LAST;
   wire logic hit_io = reg_req.io_space & io_ok & (reg_req.addr == io_ofs);
   wire logic hit_data = ~reg_req.io_space & (reg_req.addr == ccl_pkg::OUT_CTRL_DATA_OFS);
   wire logic hit = hit_io | hit_data;
   logic [7:0] ctrl_q;
   logic [7:0] rdata_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= ccl_pkg::OUT_CTRL_RESET;
         rdata_q <= 8'h00;
      end else if (clk_en) begin
         if (hit & reg_req.wr) begin
            // Only bit 0 exists; others read zero
            ctrl_q <= reg_req.wdata & 8'h01;
         end
         if (reg_req.rd) begin
            rdata_q <= hit ? ctrl_q : 8'h00;
         end
      end
   end
   assign reg_rdata = rdata_q;
   assign reg_hit = hit;

   // ------------------------------------------------------------
   // Result pin
   // ------------------------------------------------------------
   logic pin_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_q <= 1'b0;
      end else if (clk_en) begin
         pin_q <= res_q;
      end
   end
   assign result_pin = pin_q;
   assign result_pin_oe = ctrl_q[ccl_pkg::PIN_EN_BIT];
endmodule : ccl_top

// ### pkg/ccl_pkg.sv
// Purpose: Shared constants and types for the comparator control logic
// Assumes: Single clock at 100 MHz, byte-wide register port
// Notes: Register reached by data-space or I/O-space address
package ccl_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OUT_CTRL_DATA_OFS = 8'h4f;
   localparam logic [7:0] IO_SPACE_BASE = 8'h20;
   localparam logic [7:0] IO_SPACE_LAST = 8'h3f;
   localparam logic [7:0] OUT_CTRL_RESET = 8'h00;
   localparam int unsigned PIN_EN_BIT = 0;
   localparam int unsigned NUM_CHANNELS = 8;
   localparam int unsigned CHAN_SEL_W = 3;

   typedef enum logic [1:0] {
      CCL_EDGE_TOGGLE,
      CCL_EDGE_RESERVED,
      CCL_EDGE_FALL,
      CCL_EDGE_RISE
   } ccl_edge_mode_e;

   // Register access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic io_space;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ccl_reg_req_s;

   // Converter-side settings that steer the negative input
   typedef struct packed {
      logic mux_borrow_enable;
      logic converter_enable;
      logic converter_power_reduce;
      logic [CHAN_SEL_W-1:0] channel_select_low;
   } ccl_mux_cfg_s;
endpackage : ccl_pkg

// ### tb/ccl_analog.sv
// Purpose: analog pins model
// Assumes: levels in mV
// Notes: channel n at 100 mV times n
`timescale 1ns/100ps
module ccl_analog (
   input wire logic [15:0] pos_mv,
   input wire logic [15:0] neg_pin_mv,
   input wire logic [2:0] channel_sel,
   input wire logic use_channel,
   output logic raw_compare
);
   // Distinct levels so a wrong pick flips the result
   wire logic [15:0] neg_mv = use_channel ? 16'h0064 * channel_sel : neg_pin_mv;
   assign raw_compare = pos_mv > neg_mv;
endmodule : ccl_analog

// ### tb/ccl_top_assertions.sv
// Purpose: ccl_top port checks
// Assumes: checks pause while clk_en is low
// Notes: bound in bench
`timescale 1ns/100ps
module ccl_top_assertions (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire ccl_pkg::ccl_reg_req_s reg_req,
   input wire logic reg_hit,
   input wire ccl_pkg::ccl_mux_cfg_s mux_cfg,
   input wire logic [ccl_pkg::CHAN_SEL_W-1:0] neg_channel_sel,
   input wire logic neg_use_channel,
   input wire ccl_pkg::ccl_edge_mode_e irq_edge_mode,
   input wire logic irq_enable,
   input wire logic compare_result,
   input wire logic irq_flag,
   input wire logic irq_request,
   input wire logic result_pin_oe
);
   default clocking dc @(posedge clk);
   endclocking
   // Frozen state would break every next-cycle expectation
   default disable iff (!rst_b || !clk_en);
   wire logic bor = mux_cfg.mux_borrow_enable && !mux_cfg.converter_enable;
   AST_HIT: assert property (reg_hit ==
      (reg_req.addr == (reg_req.io_space ? 8'h2f : 8'h4f))) else $error("hit");
   AST_WR: assert property (reg_req.wr && reg_hit |=>
      result_pin_oe == $past(reg_req.wdata[0])) else $error("wr");
   AST_CHAN: assert property (bor |=> neg_use_channel &&
      neg_channel_sel == $past(mux_cfg.channel_select_low)) else $error("chan");
   AST_PIN: assert property (!bor |=> !neg_use_channel) else $error("pin");
   AST_RISE: assert property (irq_edge_mode == ccl_pkg::CCL_EDGE_RISE &&
      $rose(compare_result) |=> irq_flag) else $error("rise");
   AST_FALL: assert property (irq_edge_mode == ccl_pkg::CCL_EDGE_FALL &&
      $fell(compare_result) |=> irq_flag) else $error("fall");
   AST_TGL: assert property (irq_edge_mode == ccl_pkg::CCL_EDGE_TOGGLE &&
      $changed(compare_result) |=> irq_flag) else $error("tgl");
   AST_REQ: assert property (irq_request == (irq_flag && irq_enable)) else $error("req");
endmodule : ccl_top_assertions

// ### tb/ccl_top_tb.sv
// Purpose: ccl_top bench
// Assumes: clk_en high except around the frozen write
// Notes: uses ccl_analog
`timescale 1ns/100ps
module ccl_top_tb;
   logic clk = 1'b0;
   logic clk_en = 1'b1;
   logic rst_b = 1'b0;
   ccl_pkg::ccl_reg_req_s reg_req = '0;
   ccl_pkg::ccl_mux_cfg_s mux_cfg = '0;
   ccl_pkg::ccl_edge_mode_e irq_edge_mode = ccl_pkg::CCL_EDGE_RISE;
   logic [15:0] pos_mv = 16'h0200;
   logic capture_route_enable = 1'b0, irq_enable = 1'b0, irq_flag_clear = 1'b0;
   logic [7:0] reg_rdata;
   logic [2:0] neg_channel_sel;
   logic reg_hit, neg_use_channel, raw_compare, compare_result, capture_trigger;
   logic irq_flag, irq_request, result_pin, result_pin_oe, u;
   int err_count = 0;
   int checks = 0;
   ccl_top DUT (.*);
   ccl_analog u_an (.pos_mv, .neg_pin_mv(16'h0160), .channel_sel(neg_channel_sel),
      .use_channel(neg_use_channel), .raw_compare);
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk
   task automatic acc(logic w, logic io, logic [7:0] a, logic [7:0] d);
      @(posedge clk) reg_req <= '{w, !w, io, a, d};
      @(posedge clk) reg_req <= '0;
      #1;
   endtask : acc
   task automatic step(logic [15:0] mv, logic e);
      @(posedge clk) pos_mv <= mv;
      repeat (5) @(posedge clk);
      #1;
      chk("flag", 8'(e), 8'(irq_flag));
      chk("req", 8'(e && irq_enable), 8'(irq_request));
      @(posedge clk) irq_flag_clear <= 1'b1;
      @(posedge clk) irq_flag_clear <= 1'b0;
   endtask : step
   task automatic wrap_up();
      $display("checks %0d, errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up
   initial forever #5 clk = ~clk;
   initial begin
      #20000;
      err_count++;
      wrap_up();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      acc(1'b0, 1'b0, 8'h4f, 8'h00);
      chk("rst", 8'h00, reg_rdata);
      acc(1'b1, 1'b1, 8'h2f, 8'hff);
      // Data-space 0x2f is not the register
      acc(1'b1, 1'b0, 8'h2f, 8'h00);
      acc(1'b0, 1'b0, 8'h4f, 8'h00);
      chk("rdata", 8'h01, reg_rdata);
      acc(1'b0, 1'b1, 8'h4f, 8'h00);
      chk("miss", 8'h00, reg_rdata);
      chk("oe", 8'h01, 8'(result_pin_oe));
      // A write while frozen must not land
      @(posedge clk) clk_en <= 1'b0;
      acc(1'b1, 1'b0, 8'h4f, 8'h00);
      @(posedge clk) clk_en <= 1'b1;
      acc(1'b0, 1'b0, 8'h4f, 8'h00);
      chk("frozen", 8'h01, reg_rdata);
      chk("oe_frozen", 8'h01, 8'(result_pin_oe));
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) begin
            mux_cfg <= {i[0], i[1], 1'b0, 3'h7};
            capture_route_enable <= i[1];
         end
         repeat (5) @(posedge clk);
         #1;
         u = i[0] && !i[1];
         chk("use", 8'(u), 8'(neg_use_channel));
         chk("cmp", 8'(!u), 8'(compare_result));
         chk("cap", 8'(!u && i[1]), 8'(capture_trigger));
         chk("pin", 8'(!u), 8'(result_pin));
      end
      for (int m = 0; m < 4; m++) begin
         @(posedge clk) begin
            irq_edge_mode <= ccl_pkg::ccl_edge_mode_e'(m);
            irq_enable <= m[0];
         end
         step(16'h0000, m == 0 || m == 2);
         step(16'h0200, m == 0 || m == 3);
      end
      wrap_up();
   end
endmodule : ccl_top_tb
bind ccl_top ccl_top_assertions u_chk (.clk, .rst_b, .clk_en, .reg_req, .reg_hit, .mux_cfg,
   .neg_channel_sel, .neg_use_channel, .irq_edge_mode, .irq_enable, .compare_result,
   .irq_flag, .irq_request, .result_pin_oe);
